//--- flr_fault_latch.sv
/*
  Fault latch and clear handshake for a multi-axis motion controller.
  Latches mechanism, axis and processor faults, drops the fault-free and
  motion outputs, stops the motors, and clears axis faults through a request edge.
  Assumes one 100 MHz clock, synchronous inputs, reset_n as power-on.
*/
`timescale 1ns/1ps

// What this block does
// - Power-up with invalid mechanism data latches fault CEh, seven blinks.
// - Axis fault CFh, four blinks, on four causes while motion runs.
// - Axis sub-code: low nibble driver id, high nibble cause bits.
// - Axis fault clears by request; mechanism fault needs power again.
// - Processor fault F0h lights the lamp steadily until power cycle.
// - Controller fault drops fault-free, controller-free, motion; stops motors.
// - Request with cause gone clears controller fault; raises ready.
// - Driver fault drops fault-free, driver-free, motion; stops motors.
// - Request with cause gone clears driver fault; raises ready.
module flr_fault_latch #(
  parameter int BLINK_CYC = flr_pkg::FLR_BLINK_CYC,
  parameter int GAP_CYC   = flr_pkg::FLR_GAP_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Fault sources
  input  wire logic       mech_info_valid,
  input  wire logic       motion_active,
  input  wire logic       drv_comm_err,
  input  wire logic       motor_deenergised,
  input  wire logic       drv_alarm,
  input  wire logic       motor_overload,
  input  wire logic [3:0] drv_id,
  input  wire logic       cpu_fault,
  input  wire logic       motion_req,
  // Host handshake
  input  wire logic       fault_clear_request_in,
  output logic            fault_free_out,
  output logic            controller_fault_free_out,
  output logic            driver_fault_free_out,
  output logic            ready_out,
  output logic            motion_out,
  output logic            motor_stop,
  // Indication
  output logic [7:0]      fault_code,
  output logic [7:0]      fault_sub_code,
  output logic            status_lamp,
  output logic            irq
);
  import flr_pkg::*;

  logic       mech_r;
  logic       axis_r;
  logic       cpu_r;
  logic       ctrl_fault_r;
  logic       drv_fault_r;
  logic [7:0] sub_r;
  logic       por_done_r;
  logic       req_d_r;
  logic [7:0] ctrl_r;
  logic [3:0] irq_st_r;
  logic [3:0] irq_mk_r;
  logic [7:0] rdata_r;

  // Cause decode
  wire logic       ovld_en   = ctrl_r[FLR_CTRL_OVLD_EN];
  wire logic [3:0] causes    = {motor_overload & ovld_en, drv_alarm,
                                motor_deenergised, drv_comm_err};
  wire logic       axis_hit  = motion_active && (causes != 4'h0);
  wire logic       drv_cause = drv_comm_err || motor_deenergised ||
                               drv_alarm;
  wire logic       cause_now = axis_hit;

  // Clear request edge; a held request cannot clear a later fault
  wire logic req_rise  = fault_clear_request_in && !req_d_r;
  wire logic clr_ok    = req_rise && !cause_now;
  wire logic mech_set  = !por_done_r && !mech_info_valid;
  wire logic axis_set  = axis_hit && !axis_r;
  wire logic any_fault = mech_r || axis_r || cpu_r;

  // Power-on check of mechanism data, sampled once after reset release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      por_done_r <= 1'b0;
      mech_r     <= 1'b0;
    end else begin
      por_done_r <= 1'b1;
      if (mech_set) begin
        mech_r <= 1'b1;
      end
    end
  end

  // Processor fault latches until power is reapplied
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cpu_r <= 1'b0;
    end else if (cpu_fault) begin
      cpu_r <= 1'b1;
    end
  end

  // Axis fault with sub-code; a new fault wins over a clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      axis_r <= 1'b0;
      sub_r  <= 8'h00;
    end else if (axis_set) begin
      axis_r <= 1'b1;
      sub_r  <= {causes, drv_id};
    end else if (clr_ok && axis_r) begin
      axis_r <= 1'b0;
      sub_r  <= 8'h00;
    end
  end

  // Which side owns the active axis fault; driver alarms are driver side
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      drv_fault_r  <= 1'b0;
      ctrl_fault_r <= 1'b0;
    end else if (axis_set) begin
      drv_fault_r  <= drv_cause;
      ctrl_fault_r <= !drv_cause;
    end else if (clr_ok) begin
      drv_fault_r  <= 1'b0;
      ctrl_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= fault_clear_request_in;
    end
  end

  // Handshake outputs; host waits on these before releasing the request
  wire logic ctrl_bad = ctrl_fault_r || mech_r || cpu_r;
  assign controller_fault_free_out = !ctrl_bad;
  assign driver_fault_free_out     = !drv_fault_r;
  assign fault_free_out            = !ctrl_bad && !drv_fault_r;
  assign ready_out                 = !any_fault && por_done_r;
  assign motion_out                = ready_out && motion_req;
  assign motor_stop                = any_fault;

  // Reported code, processor fault first
  assign fault_code = cpu_r  ? FLR_CODE_CPU  :
                      mech_r ? FLR_CODE_MECH :
                      axis_r ? FLR_CODE_AXIS : FLR_CODE_NONE;
  assign fault_sub_code = sub_r;

  // Lamp pattern select
  wire logic [3:0] blinks = mech_r ? FLR_BLINK_MECH :
                            axis_r ? FLR_BLINK_AXIS : 4'h0;

  flr_lamp #(
    .BLINK_CYC (BLINK_CYC),
    .GAP_CYC   (GAP_CYC)
  ) u_lamp (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .blink_count (blinks),
    .steady      (cpu_r),
    .status_lamp (status_lamp)
  );

  // Register decode
  wire logic wr_ctrl  = reg_wr && (reg_addr == FLR_REG_CTRL);
  wire logic wr_irqst = reg_wr && (reg_addr == FLR_REG_IRQ_ST);
  wire logic wr_irqmk = reg_wr && (reg_addr == FLR_REG_IRQ_MK);
  // Clear-done only when a clearable fault really went away
  wire logic [3:0] irq_ev = {clr_ok & axis_r, cpu_fault & !cpu_r,
                             axis_set, mech_set};
  wire logic [3:0] irq_clr = wr_irqst ? reg_wdata[3:0] : 4'h0;

  // Control and mask registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_r   <= FLR_CTRL_RESET;
      irq_mk_r <= FLR_IRQ_MK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata;
      end
      if (wr_irqmk) begin
        irq_mk_r <= reg_wdata[3:0];
      end
    end
  end

  // Sticky status; an event in the clear cycle survives
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_st_r <= 4'h0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
    end
  end

  assign irq = |(irq_st_r & irq_mk_r);

  // Read mux; unmapped addresses read zero
  wire logic [7:0] rd_mux =
    (reg_addr == FLR_REG_CTRL)   ? ctrl_r :
    (reg_addr == FLR_REG_STATUS) ? {2'h0, ready_out, motion_out,
                                    drv_fault_r, cpu_r, axis_r, mech_r} :
    (reg_addr == FLR_REG_CODE)   ? fault_code :
    (reg_addr == FLR_REG_IRQ_ST) ? {4'h0, irq_st_r} :
    (reg_addr == FLR_REG_IRQ_MK) ? {4'h0, irq_mk_r} : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

//--- flr_fault_latch_bench.sv
/* Bench for the fault latch: register tasks and fault sequences.
   Assumes the host model and checker files are compiled alongside. */
`timescale 1ns/1ps
module flr_fault_latch_bench;
  import flr_pkg::*;
  logic       clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, drv_id = 4'h0, id;
  logic [7:0] reg_wdata = 8'h00, rdata, code, sub;
  logic       mech_ok = 1'b1, mact = 1'b0, ovl = 1'b0, cpu = 1'b0;
  logic       go = 1'b0, hold = 1'b0, mreq = 1'b0;
  logic [2:0] dc = 3'h0;
  logic       req, ff, cf, df, rdy, mo, ms, lamp, irq;
  int         err_total = 0, n_checks = 0, i;

  flr_fault_latch #(.BLINK_CYC(4), .GAP_CYC(8)) flr_fault_latch_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .mech_info_valid(mech_ok), .motion_active(mact),
    .drv_comm_err(dc[0]), .motor_deenergised(dc[1]), .drv_alarm(dc[2]),
    .motor_overload(ovl), .drv_id(drv_id), .cpu_fault(cpu),
    .motion_req(mreq), .fault_clear_request_in(req), .fault_free_out(ff),
    .controller_fault_free_out(cf), .driver_fault_free_out(df),
    .ready_out(rdy), .motion_out(mo), .motor_stop(ms), .fault_code(code),
    .fault_sub_code(sub), .status_lamp(lamp), .irq(irq));
  flr_host_model flr_host_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .go(go), .hold(hold), .fault_free_out(ff), .unit_free(cf & df),
    .fault_clear_request_in(req));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  // One-cycle cause while motion runs; outputs settled on return
  task fault(input logic [2:0] c, input logic ov, input logic [3:0] d);
    @(posedge clk_sys);
    mact <= 1'b1;
    dc <= c;
    ovl <= ov;
    drv_id <= d;
    @(posedge clk_sys);
    dc <= 3'h0;
    ovl <= 1'b0;
    #1;
  endtask
  // Host handshake, cause already removed; bounded wait for release
  task clear;
    int k;
    @(posedge clk_sys);
    go <= 1'b1;
    for (k = 0; k < 50 && !(k > 1 && !req); k++) @(posedge clk_sys);
    if (k == 50) begin
      err_total++;
      report_and_stop;
    end
    go <= 1'b0;
    #1;
  endtask
  // Counts flashes between two gaps; a gap is six or more dark cycles
  task blinks(input logic [7:0] e);
    int lo, n, k;
    logic p;
    lo = 0;
    n = 0;
    p = 1'b0;
    for (k = 0; k < 300 && lo < 6; k++) #10 lo = lamp ? 0 : lo + 1;
    lo = 0;
    for (k = 0; k < 300 && !(n > 0 && lo >= 6); k++) begin
      #10 n = n + int'(lamp && !p);
      lo = lamp ? 0 : lo + 1;
      p = lamp;
    end
    if (k == 300) begin
      err_total++;
      report_and_stop;
    end
    check(n[7:0], e);
  endtask

  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    tick(20);
    reset_n <= 1'b1;
    mreq <= 1'b1;
    tick(2);
    rd(FLR_REG_CTRL, FLR_CTRL_RESET);
    rd(FLR_REG_IRQ_MK, 8'h00);
    rd(4'h3, 8'h00);
    rd(FLR_REG_STATUS, 8'h30);
    // Each driver cause with its own id, cleared by the host
    for (i = 0; i < 3; i++) begin
      id = 4'(3 + i * 6);
      fault(3'h1 << i, 1'b0, id);
      check({ff, df, cf, mo, ms, 3'h0}, 8'h28);
      check(code, FLR_CODE_AXIS);
      check(sub, {4'h1 << i, id});
      rd(FLR_REG_STATUS, 8'h0A);
      clear;
      check({ff, df, cf, rdy, 4'h0}, 8'hF0);
    end
    // Interrupt masked, raised, cleared
    check({7'h0, irq}, 8'h00);
    rd(FLR_REG_IRQ_ST, 8'h0A);
    wr(FLR_REG_IRQ_MK, 8'h02);
    #1 check({7'h0, irq}, 8'h01);
    wr(FLR_REG_IRQ_ST, 8'h02);
    #1 check({7'h0, irq}, 8'h00);
    rd(FLR_REG_IRQ_ST, 8'h08);
    // Overload counts only when enabled
    fault(3'h0, 1'b1, 4'h2);
    check(code, FLR_CODE_NONE);
    wr(FLR_REG_CTRL, 8'h01);
    fault(3'h0, 1'b1, 4'h2);
    check({ff, df, cf, mo, ms, 3'h0}, 8'h48);
    check(sub, 8'h82);
    blinks(FLR_BLINK_AXIS);
    // Request held high must not clear a later fault
    @(posedge clk_sys);
    hold <= 1'b1;
    go <= 1'b1;
    tick(6);
    #1 check({ff, cf, rdy, 5'h0}, 8'hE0);
    fault(3'h4, 1'b0, 4'h1);
    tick(4);
    #1 check({7'h0, ff}, 8'h00);
    @(posedge clk_sys);
    go <= 1'b0;
    hold <= 1'b0;
    tick(2);
    clear;
    check({7'h0, ff}, 8'h01);
    // Processor fault over a blinking axis fault: steady wins, no clear
    fault(3'h4, 1'b0, 4'h5);
    @(posedge clk_sys);
    cpu <= 1'b1;
    @(posedge clk_sys);
    cpu <= 1'b0;
    #1 check({ff, cf, mo, ms, 4'h0}, 8'h10);
    check(code, FLR_CODE_CPU);
    tick(3);
    for (i = 0; i < 20; i++) #10 check({7'h0, lamp}, 8'h01);
    @(posedge clk_sys);
    go <= 1'b1;
    tick(6);
    #1 check(code, FLR_CODE_CPU);
    check({ff, cf, rdy, 5'h0}, 8'h00);
    @(posedge clk_sys);
    go <= 1'b0;
    // Power-up with invalid mechanism data
    @(posedge clk_sys);
    reset_n <= 1'b0;
    mech_ok <= 1'b0;
    tick(3);
    reset_n <= 1'b1;
    tick(3);
    #1 check(code, FLR_CODE_MECH);
    blinks(FLR_BLINK_MECH);
    @(posedge clk_sys);
    mech_ok <= 1'b1;
    go <= 1'b1;
    tick(6);
    #1 check(code, FLR_CODE_MECH);
    check({ff, cf, rdy, 5'h0}, 8'h00);
    report_and_stop;
  end
endmodule

//--- flr_fault_latch_chk.sv
/* Port checker for the fault latch.
   Assumes one clock domain and binds to every fault latch instance. */
`timescale 1ns/1ps
module flr_fault_latch_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Fault sources and host request
  input wire logic       mech_info_valid,
  input wire logic       motion_active,
  input wire logic       drv_comm_err,
  input wire logic       motor_deenergised,
  input wire logic       drv_alarm,
  input wire logic       motor_overload,
  input wire logic [3:0] drv_id,
  input wire logic       cpu_fault,
  input wire logic       fault_clear_request_in,
  // Outputs watched
  input wire logic       fault_free_out,
  input wire logic       controller_fault_free_out,
  input wire logic       driver_fault_free_out,
  input wire logic       ready_out,
  input wire logic       motion_out,
  input wire logic       motor_stop,
  input wire logic [7:0] fault_code,
  input wire logic [7:0] fault_sub_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Clear precondition: no cause input high; the latch itself blocks a clear only on causes seen while motion runs
  wire any_cause = drv_comm_err | motor_deenergised | drv_alarm
                 | motor_overload | cpu_fault;
  wire all_free  = fault_free_out & controller_fault_free_out
                 & driver_fault_free_out & ready_out;

  AST_MECH_UP: assert property (
    $rose(reset_n) && !mech_info_valid |=> fault_code inside {8'hCE, 8'hF0})
    else $error("mechanism fault missing after power-up");
  AST_MECH_KEEP: assert property (
    fault_code == 8'hCE |=> fault_code inside {8'hCE, 8'hF0})
    else $error("mechanism fault cleared without power-up");
  AST_DRV_STOP: assert property (
    motion_active && drv_alarm |=> !fault_free_out && !driver_fault_free_out
      && !motion_out && motor_stop)
    else $error("driver fault did not stop motion");
  AST_SUB: assert property (
    motion_active && drv_alarm && !drv_comm_err && !motor_deenergised
      && !motor_overload && fault_code == 8'h00
      |=> fault_code == 8'hCF && fault_sub_code == {4'h4, $past(drv_id)})
    else $error("axis code or sub-code wrong");
  AST_CPU: assert property (
    cpu_fault |=> fault_code == 8'hF0 && !controller_fault_free_out
      && !fault_free_out && !motion_out && motor_stop)
    else $error("processor fault outputs wrong");
  AST_CPU_KEEP: assert property (
    fault_code == 8'hF0 |=> fault_code == 8'hF0)
    else $error("processor fault cleared without power-up");
  AST_CLEAR: assert property (
    $rose(fault_clear_request_in) && fault_code == 8'hCF && !any_cause
      |=> all_free)
    else $error("clear request did not clear axis fault");
  AST_HELD: assert property (
    fault_clear_request_in && $past(fault_clear_request_in)
      && !fault_free_out |=> !fault_free_out)
    else $error("held request cleared a fault");

  // Main scenarios reached
  COV_CLEAR: cover property ($rose(fault_clear_request_in) ##1 all_free);
  COV_CPU: cover property (cpu_fault ##1 fault_code == 8'hF0);
  COV_MECH: cover property ($rose(reset_n) && !mech_info_valid);
endmodule

bind flr_fault_latch flr_fault_latch_chk flr_fault_latch_chk_i (.*);

//--- flr_host_model.sv
/* Host controller model driving the fault-clear request.
   Assumes the bench raises go only after removing the fault cause. */
`timescale 1ns/1ps
module flr_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench control; hold keeps the request up on purpose
  input wire logic go,
  input wire logic hold,
  // Device outputs
  input wire logic fault_free_out,
  input wire logic unit_free,
  // Request
  output logic     fault_clear_request_in
);
  logic go_q;
  // Raise once per go, release after both outputs show free while hold is low, or when go falls
  always_ff @(posedge clk_sys) begin
    go_q <= go & reset_n;
    if (!reset_n || !go) begin
      fault_clear_request_in <= 1'b0;
    end else if (!go_q) begin
      fault_clear_request_in <= 1'b1;
    end else if (fault_free_out && unit_free && !hold) begin
      fault_clear_request_in <= 1'b0;
    end
  end
endmodule

//--- flr_lamp.sv
/*
  Status lamp sequencer: a burst of blink_count flashes then a long gap,
  or steady light when steady is high, or lit when idle (power good).
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module flr_lamp #(
  parameter int BLINK_CYC = flr_pkg::FLR_BLINK_CYC,
  parameter int GAP_CYC   = flr_pkg::FLR_GAP_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Pattern select
  input  wire logic [3:0] blink_count,
  input  wire logic       steady,
  // Lamp
  output logic            status_lamp
);
  import flr_pkg::*;

  flr_lamp_e   state_r;
  logic [31:0] tick_r;
  logic [3:0]  done_r;
  logic        lamp_r;

  wire logic blinking = (blink_count != 4'h0) && !steady;
  wire logic tick_end = (state_r == FLR_LAMP_GAP_ST) ?
                        (tick_r >= 32'(GAP_CYC - 1)) :
                        (tick_r >= 32'(BLINK_CYC - 1));

  // Burst sequencer; restarts whenever the pattern is not a blink code
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !blinking) begin
      state_r <= FLR_LAMP_GAP_ST;
      tick_r  <= 32'h0;
      done_r  <= 4'h0;
    end else if (!tick_end) begin
      tick_r <= tick_r + 32'h1;
    end else begin
      tick_r <= 32'h0;
      unique case (state_r)
        FLR_LAMP_ON_ST: begin
          state_r <= FLR_LAMP_OFF_ST;
          done_r  <= done_r + 4'h1;
        end
        FLR_LAMP_OFF_ST: begin
          state_r <= (done_r == blink_count) ? FLR_LAMP_GAP_ST
                                             : FLR_LAMP_ON_ST;
        end
        FLR_LAMP_GAP_ST: begin
          state_r <= FLR_LAMP_ON_ST;
          done_r  <= 4'h0;
        end
      endcase
    end
  end

  // Lamp drive from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lamp_r <= 1'b0;
    end else begin
      lamp_r <= steady || !blinking || (state_r == FLR_LAMP_ON_ST);
    end
  end

  assign status_lamp = lamp_r;

endmodule

//--- flr_pkg.sv
/*
  Package for the fault latch and clear handshake block: fault codes,
  lamp blink counts, sub-code layout, register map and lamp timing.
  Assumes a 100 MHz system clock and a plain register port.
*/
package flr_pkg;

  // Fault codes
  localparam logic [7:0] FLR_CODE_NONE  = 8'h00;
  localparam logic [7:0] FLR_CODE_MECH  = 8'hCE;
  localparam logic [7:0] FLR_CODE_AXIS  = 8'hCF;
  localparam logic [7:0] FLR_CODE_CPU   = 8'hF0;

  // Lamp blink counts
  localparam logic [3:0] FLR_BLINK_MECH = 4'h7;
  localparam logic [3:0] FLR_BLINK_AXIS = 4'h4;

  // Sub-code layout: low nibble driver id, high nibble cause bits
  localparam int FLR_SUB_ID_LSB    = 0;
  localparam int FLR_SUB_CAUSE_LSB = 4;
  localparam int FLR_CAUSE_COMM    = 0;
  localparam int FLR_CAUSE_NOEXC   = 1;
  localparam int FLR_CAUSE_DRVALM  = 2;
  localparam int FLR_CAUSE_OVLD    = 3;

  // Register offsets
  localparam logic [3:0] FLR_REG_CTRL   = 4'h0;
  localparam logic [3:0] FLR_REG_STATUS = 4'h4;
  localparam logic [3:0] FLR_REG_CODE   = 4'h8;
  localparam logic [3:0] FLR_REG_IRQ_ST = 4'hC;
  localparam logic [3:0] FLR_REG_IRQ_MK = 4'h5;

  // Control fields and reset values
  localparam int         FLR_CTRL_OVLD_EN = 0;
  localparam logic [7:0] FLR_CTRL_RESET   = 8'h00;
  localparam logic [3:0] FLR_IRQ_MK_RESET = 4'h0;

  // Interrupt status bit positions
  localparam int FLR_IRQ_MECH  = 0;
  localparam int FLR_IRQ_AXIS  = 1;
  localparam int FLR_IRQ_CPU   = 2;
  localparam int FLR_IRQ_CLEAR = 3;

  // Lamp timing
  localparam int FLR_CLK_MHZ    = 100;
  localparam int FLR_BLINK_MS   = 250;
  localparam int FLR_GAP_MS     = 1000;
  localparam int FLR_BLINK_CYC  = FLR_BLINK_MS * 1000 * FLR_CLK_MHZ;
  localparam int FLR_GAP_CYC    = FLR_GAP_MS * 1000 * FLR_CLK_MHZ;

  // Lamp sequencer states
  typedef enum logic [1:0] {
    FLR_LAMP_ON_ST,
    FLR_LAMP_OFF_ST,
    FLR_LAMP_GAP_ST
  } flr_lamp_e;

endpackage
